// ---- inc/memory_controller_pkg.sv ----
// constants used by the memory controller unit; the bench and checker repeat the values as literals
package memory_controller_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] REMAP_CONTROL_OFFS = 8'h00;
	localparam logic [7:0] ABORT_STATUS_OFFS  = 8'h04;
	localparam logic [7:0] ABORT_ADDRESS_OFFS = 8'h08;

	localparam int REMAP_TOGGLE_BIT_POS    = 0;
	localparam int UNDEFINED_ADDR_FLAG_POS = 0;
	localparam int MISALIGNED_FLAG_POS     = 1;
	localparam int ABORT_SIZE_FIELD_POS    = 8;
	localparam int ABORT_TYPE_FIELD_POS    = 10;
	localparam int DMA_LAST_ABORT_FLAG_POS = 16;
	localparam int CPU_LAST_ABORT_FLAG_POS = 17;
	localparam int DMA_ABORT_SEEN_FLAG_POS = 24;
	localparam int CPU_ABORT_SEEN_FLAG_POS = 25;

	localparam logic [31:0] ABORT_STATUS_RESET  = 32'h0000_0000;
	localparam logic [31:0] ABORT_ADDRESS_RESET = 32'h0000_0000;
	localparam logic        REMAP_RESET         = 1'b0;

	// ************************************************************
	// access encodings
	// ************************************************************
	localparam logic [1:0] SIZE_BYTE  = 2'h0;
	localparam logic [1:0] SIZE_HALF  = 2'h1;
	localparam logic [1:0] SIZE_WORD  = 2'h2;
	localparam logic [1:0] TYPE_READ  = 2'h0;
	localparam logic [1:0] TYPE_WRITE = 2'h1;
	localparam logic [1:0] TYPE_FETCH = 2'h2;

	// ************************************************************
	// address decode
	// ************************************************************
	localparam logic [3:0] REGION_INTERNAL = 4'h0;
	localparam logic [3:0] REGION_PERIPH   = 4'hF;
	localparam logic [7:0] SLOT_AREA0      = 8'h00;
	localparam logic [7:0] SLOT_FLASH      = 8'h01;
	localparam logic [7:0] SLOT_SRAM       = 8'h02;
	localparam logic [7:0] SLOT_SILENT     = 8'h03;
	localparam int         SLOT_BITS       = 20;

endpackage

// ---- rtl/memory_controller_unit.sv ----
// memory controller unit: arbiter, decoder, remap, misalignment and abort capture
`timescale 1ns/1ps

// How it works
// - dma master always wins over processor
// - top address nibble selects the region
// - undefined regions abort the access
// - next eight bits pick a 1-Mbyte slot
// - small memories alias across their slot
// - unassigned internal slots abort
// - slot three aborts only when misaligned, selects nothing
// - remap picks flash or sram for area zero
// - area zero memory also at home address
// - writing one toggles remap, reset clears
// - abort goes to both masters
// - full abort address is captured
// - abort size and type are recorded
// - undefined and misaligned flags per cause
// - last aborting master is marked
// - per-master sticky flags, cleared by read
// - data abort captures data address
// - misaligned word or half-word aborts
// - instruction fetches skip alignment check
// - little-endian accesses only
// - size field: byte, half, word
// - type field: read, write, fetch
// - writing zero leaves remap alone
module memory_controller_unit #(
	parameter int FLASH_AW = 18,
	parameter int SRAM_AW  = 16
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        dma_req,
	input  wire logic [31:0] dma_addr,
	input  wire logic        dma_wr,
	input  wire logic [1:0]  dma_size,
	input  wire logic [31:0] dma_wdata,
	input  wire logic        cpu_req,
	input  wire logic [31:0] cpu_addr,
	input  wire logic        cpu_wr,
	input  wire logic        cpu_fetch,
	input  wire logic [1:0]  cpu_size,
	input  wire logic [31:0] cpu_wdata,
	output logic             dma_grant,
	output logic             cpu_grant,
	output logic             abort,
	output logic             flash_sel,
	output logic             sram_sel,
	output logic             periph_sel,
	output logic             mem_wr,
	output logic [1:0]       mem_size,
	output logic [31:0]      mem_addr,
	output logic [31:0]      mem_wdata,
	output logic             remap_active
);

	// the alias mask cannot reach past one 1-Mbyte slot
	if (FLASH_AW < 1 || FLASH_AW > memory_controller_pkg::SLOT_BITS ||
		SRAM_AW < 1 || SRAM_AW > memory_controller_pkg::SLOT_BITS) begin
		$error("memory address widths must lie within one slot");
	end

	// ************************************************************
	// arbitration
	// ************************************************************
	logic        use_dma;
	logic        any_req;
	logic [31:0] a_addr;
	logic        a_wr;
	logic        a_fetch;
	logic [1:0]  a_size;
	logic [31:0] a_wdata;

	always_comb begin
		use_dma = dma_req;
		any_req = dma_req | cpu_req;
		a_addr  = use_dma ? dma_addr : cpu_addr;
		a_wr    = use_dma ? dma_wr : cpu_wr;
		a_fetch = use_dma ? 1'b0 : cpu_fetch;
		a_size  = use_dma ? dma_size : cpu_size;
		a_wdata = use_dma ? dma_wdata : cpu_wdata;
	end

	// ************************************************************
	// decode
	// ************************************************************
	logic        remap_ff;
	logic        hit_flash;
	logic        hit_sram;
	logic        hit_periph;
	logic        hit_silent;
	logic        undef;
	logic        misalign;
	logic        do_abort;
	logic [7:0]  slot;
	logic [31:0] alias_addr;

	// keeps only the low bits a memory really decodes
	function automatic logic [31:0] alias_mask(input logic [31:0] addr, input int aw);
		logic [31:0] m;
		m = (32'h0000_0001 << aw) - 32'h0000_0001;
		return addr & m;
	endfunction

	always_comb begin
		slot       = a_addr[27:20];
		hit_flash  = 1'b0;
		hit_sram   = 1'b0;
		hit_periph = 1'b0;
		hit_silent = 1'b0;
		undef      = 1'b0;
		alias_addr = a_addr;
		if (a_addr[31:28] == memory_controller_pkg::REGION_PERIPH) begin
			hit_periph = 1'b1;
		end else if (a_addr[31:28] == memory_controller_pkg::REGION_INTERNAL) begin
			if (slot == memory_controller_pkg::SLOT_AREA0) begin
				hit_flash = ~remap_ff;
				hit_sram  = remap_ff;
			end else if (slot == memory_controller_pkg::SLOT_FLASH) begin
				hit_flash = 1'b1;
			end else if (slot == memory_controller_pkg::SLOT_SRAM) begin
				hit_sram = 1'b1;
			end else if (slot == memory_controller_pkg::SLOT_SILENT) begin
				hit_silent = 1'b1;
			end else begin
				undef = 1'b1;
			end
		end else begin
			undef = 1'b1;
		end
		// peripherals decode their own address, so it passes unaliased
		if (hit_flash) begin
			alias_addr = alias_mask(a_addr, FLASH_AW);
		end else if (hit_sram) begin
			alias_addr = alias_mask(a_addr, SRAM_AW);
		end
		// fetches are exempt: prefetch aborts are handled by the core itself
		misalign = ~a_fetch &
			(((a_size == memory_controller_pkg::SIZE_WORD) && (a_addr[1:0] != 2'h0)) ||
			((a_size == memory_controller_pkg::SIZE_HALF) && a_addr[0]));
		do_abort = any_req & (undef | misalign);
	end

	// ************************************************************
	// access issue
	// ************************************************************
	// a grant is a one-cycle pulse for each edge that takes a request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma_grant <= 1'b0;
			cpu_grant <= 1'b0;
		end else begin
			dma_grant <= dma_req;
			cpu_grant <= cpu_req & ~dma_req;
		end
	end

	// one abort line feeds both masters; each decides if it applies
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			abort <= 1'b0;
		end else begin
			abort <= do_abort;
		end
	end

	// misaligned accesses are cancelled, so no select reaches a memory
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_sel  <= 1'b0;
			sram_sel   <= 1'b0;
			periph_sel <= 1'b0;
			mem_wr     <= 1'b0;
			mem_size   <= 2'h0;
			mem_addr   <= 32'h0000_0000;
			mem_wdata  <= 32'h0000_0000;
		end else begin
			flash_sel  <= any_req & hit_flash & ~misalign;
			sram_sel   <= any_req & hit_sram & ~misalign;
			periph_sel <= any_req & hit_periph & ~misalign;
			mem_wr     <= any_req & a_wr & ~do_abort & ~hit_silent;
			mem_size   <= a_size;
			mem_addr   <= alias_addr;
			mem_wdata  <= a_wdata;
		end
	end

	// ************************************************************
	// apb slave
	// ************************************************************
	logic       setup;
	logic       access;
	logic       reg_hit;
	logic       rd_status;
	logic [1:0] read_seen_ff;
	logic       wr_remap;

	always_comb begin
		setup    = psel & ~penable;
		access   = psel & penable & pready;
		reg_hit  = (paddr == memory_controller_pkg::REMAP_CONTROL_OFFS) ||
			(paddr == memory_controller_pkg::ABORT_STATUS_OFFS) ||
			(paddr == memory_controller_pkg::ABORT_ADDRESS_OFFS);
		rd_status = access & ~pwrite & (paddr == memory_controller_pkg::ABORT_STATUS_OFFS);
		wr_remap  = access & pwrite & (paddr == memory_controller_pkg::REMAP_CONTROL_OFFS);
	end

	// ************************************************************
	// remap state
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			remap_ff     <= memory_controller_pkg::REMAP_RESET;
			remap_active <= memory_controller_pkg::REMAP_RESET;
		end else begin
			// a toggle, not a set: the same write undoes a remap
			if (wr_remap && pwdata[memory_controller_pkg::REMAP_TOGGLE_BIT_POS]) begin
				remap_ff     <= ~remap_ff;
				remap_active <= ~remap_ff;
			end
		end
	end

	// ************************************************************
	// abort capture
	// ************************************************************
	logic        undefined_addr_flag_ff;
	logic        misaligned_flag_ff;
	logic [1:0]  abort_size_field_ff;
	logic [1:0]  abort_type_field_ff;
	logic        dma_last_abort_flag_ff;
	logic        cpu_last_abort_flag_ff;
	logic        dma_abort_seen_flag_ff;
	logic        cpu_abort_seen_flag_ff;
	logic [31:0] abort_address_field_ff;
	logic [31:0] status_word;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			undefined_addr_flag_ff <= 1'b0;
			misaligned_flag_ff     <= 1'b0;
			abort_size_field_ff    <= 2'h0;
			abort_type_field_ff    <= 2'h0;
			dma_last_abort_flag_ff <= 1'b0;
			cpu_last_abort_flag_ff <= 1'b0;
			abort_address_field_ff <= memory_controller_pkg::ABORT_ADDRESS_RESET;
		end else if (do_abort) begin
			abort_address_field_ff <= a_addr;
			undefined_addr_flag_ff <= undef;
			misaligned_flag_ff     <= misalign;
			abort_size_field_ff    <= a_size;
			abort_type_field_ff    <= a_fetch ? memory_controller_pkg::TYPE_FETCH :
				(a_wr ? memory_controller_pkg::TYPE_WRITE : memory_controller_pkg::TYPE_READ);
			dma_last_abort_flag_ff <= use_dma;
			cpu_last_abort_flag_ff <= ~use_dma;
		end
	end

	// only bits that software actually saw are cleared; a new abort always wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma_abort_seen_flag_ff <= 1'b0;
			cpu_abort_seen_flag_ff <= 1'b0;
		end else begin
			if (do_abort && use_dma) begin
				dma_abort_seen_flag_ff <= 1'b1;
			end else if (rd_status && read_seen_ff[0]) begin
				dma_abort_seen_flag_ff <= 1'b0;
			end
			if (do_abort && !use_dma) begin
				cpu_abort_seen_flag_ff <= 1'b1;
			end else if (rd_status && read_seen_ff[1]) begin
				cpu_abort_seen_flag_ff <= 1'b0;
			end
		end
	end

	// reserved bits read as zero
	always_comb begin
		status_word = memory_controller_pkg::ABORT_STATUS_RESET;
		status_word[memory_controller_pkg::UNDEFINED_ADDR_FLAG_POS] = undefined_addr_flag_ff;
		status_word[memory_controller_pkg::MISALIGNED_FLAG_POS]     = misaligned_flag_ff;
		status_word[memory_controller_pkg::ABORT_SIZE_FIELD_POS +: 2] = abort_size_field_ff;
		status_word[memory_controller_pkg::ABORT_TYPE_FIELD_POS +: 2] = abort_type_field_ff;
		status_word[memory_controller_pkg::DMA_LAST_ABORT_FLAG_POS] = dma_last_abort_flag_ff;
		status_word[memory_controller_pkg::CPU_LAST_ABORT_FLAG_POS] = cpu_last_abort_flag_ff;
		status_word[memory_controller_pkg::DMA_ABORT_SEEN_FLAG_POS] = dma_abort_seen_flag_ff;
		status_word[memory_controller_pkg::CPU_ABORT_SEEN_FLAG_POS] = cpu_abort_seen_flag_ff;
	end

	// ************************************************************
	// apb answer
	// ************************************************************
	// zero wait states: every setup cycle is answered in the next clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~reg_hit;
		end
	end

	// read data is sampled in the setup cycle so the access cycle can answer from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata       <= 32'h0000_0000;
			read_seen_ff <= 2'h0;
		end else begin
			if (setup && !pwrite) begin
				unique case (paddr)
					memory_controller_pkg::ABORT_STATUS_OFFS: begin
						prdata       <= status_word;
						read_seen_ff <= {cpu_abort_seen_flag_ff, dma_abort_seen_flag_ff};
					end
					memory_controller_pkg::ABORT_ADDRESS_OFFS: begin
						prdata       <= abort_address_field_ff;
						read_seen_ff <= 2'h0;
					end
					default: begin
						prdata       <= 32'h0000_0000;
						read_seen_ff <= 2'h0;
					end
				endcase
			end
		end
	end

endmodule

// ---- verification/memory_controller_asserts.sv ----
// checker of the memory controller unit ports
`timescale 1ns/1ps
module memory_controller_asserts (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        dma_req,
	input wire logic [31:0] dma_addr,
	input wire logic [1:0]  dma_size,
	input wire logic        cpu_req,
	input wire logic [31:0] cpu_addr,
	input wire logic        cpu_fetch,
	input wire logic        dma_grant,
	input wire logic        cpu_grant,
	input wire logic        abort,
	input wire logic        flash_sel,
	input wire logic        sram_sel,
	input wire logic        periph_sel,
	input wire logic        mem_wr,
	input wire logic        remap_active
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic rmw;
	assign rmw = psel && penable && pready && pwrite && paddr == 8'h00;
	a_dma_wins: assert property (dma_req |=> dma_grant && !cpu_grant)
		else $error("dma not sole grant");
	a_undef_aborts: assert property (dma_req && !(dma_addr[31:28] inside {4'h0, 4'hF})
		|=> abort) else $error("undefined region not aborted");
	a_abort_quiet: assert property (abort |-> !(flash_sel || sram_sel || periph_sel || mem_wr))
		else $error("aborted access reached memory");
	a_silent_slot: assert property (dma_req && dma_addr[31:20] == 12'h003 && dma_size == 2'h0
		|=> dma_grant && !abort && !mem_wr) else $error("silent slot misbehaved");
	a_misalign_abort: assert property (dma_req && dma_size == 2'h2 && dma_addr[1:0] != 2'h0
		|=> abort) else $error("misaligned word not aborted");
	a_fetch_unchecked: assert property (cpu_req && !dma_req && cpu_fetch
		&& cpu_addr[31:20] == 12'h001 |=> flash_sel && !abort) else $error("fetch checked");
	a_remap_toggles: assert property (rmw && pwdata[0] |=> remap_active != $past(remap_active))
		else $error("remap did not toggle");
	a_remap_holds: assert property (rmw && !pwdata[0] |=> $stable(remap_active))
		else $error("remap changed on zero");
	a_area0_remap: assert property (dma_req && dma_addr[31:20] == 12'h000 && dma_size == 2'h0
		|=> sram_sel == $past(remap_active) && flash_sel == !$past(remap_active))
		else $error("area zero wrong memory");
	c_cpu_abort: cover property (cpu_grant && abort);
	c_contend: cover property (dma_req && cpu_req);
	c_remapped: cover property (remap_active && sram_sel);
endmodule

bind memory_controller_unit memory_controller_asserts u_memory_controller_asserts (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .dma_req(dma_req), .dma_addr(dma_addr),
	.dma_size(dma_size), .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_fetch(cpu_fetch),
	.dma_grant(dma_grant), .cpu_grant(cpu_grant), .abort(abort), .flash_sel(flash_sel),
	.sram_sel(sram_sel), .periph_sel(periph_sel), .mem_wr(mem_wr), .remap_active(remap_active));

// ---- verification/bus_masters_model.sv ----
// dma and processor bus master models
`timescale 1ns/1ps
module bus_masters_model (
	input  wire logic        pclk,
	input  wire logic        dma_grant,
	input  wire logic        cpu_grant,
	input  wire logic        abort,
	output logic             dma_req,
	output logic [31:0]      dma_addr,
	output logic             dma_wr,
	output logic [1:0]       dma_size,
	output logic [31:0]      dma_wdata,
	output logic             cpu_req,
	output logic [31:0]      cpu_addr,
	output logic             cpu_wr,
	output logic             cpu_fetch,
	output logic [1:0]       cpu_size,
	output logic [31:0]      cpu_wdata
);
	int cpu_faults;
	initial begin
		{dma_req, dma_addr, dma_wr, dma_size, dma_wdata} = '0;
		{cpu_req, cpu_addr, cpu_wr, cpu_fetch, cpu_size, cpu_wdata} = '0;
		cpu_faults = 0;
	end
	// data lanes stay little-endian, never swapped
	task automatic access(input bit d, input logic [31:0] a, input logic w, f,
		input logic [1:0] s, input logic [31:0] wd, output logic g);
		@(posedge pclk);
		if (d)
			{dma_req, dma_addr, dma_wr, dma_size, dma_wdata} <= {1'b1, a, w, s, wd};
		else
			{cpu_req, cpu_addr, cpu_wr, cpu_fetch, cpu_size, cpu_wdata} <= {1'b1, a, w, f, s, wd};
		@(posedge pclk);
		// processor holds its request while dma owns the bus
		while (!d && dma_req === 1'b1)
			@(posedge pclk);
		// released address and data lines show the inverse so stale values never pass
		if (d)
			{dma_req, dma_addr, dma_wdata} <= {1'b0, ~a, ~wd};
		else
			{cpu_req, cpu_addr, cpu_wdata} <= {1'b0, ~a, ~wd};
		#1;
		g = d ? dma_grant : cpu_grant;
		// dma ignores abort; processor takes it only for its own access
		if (!d && cpu_grant === 1'b1 && abort === 1'b1)
			cpu_faults++;
	endtask
endmodule

// ---- verification/memory_controller_unit_tb.sv ----
// self-checking bench for the memory controller unit
`timescale 1ns/1ps
module memory_controller_unit_tb;
	localparam int FAW = 18;
	localparam int SAW = 16;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, g;
	logic        dma_req, dma_wr, cpu_req, cpu_wr, cpu_fetch, dma_grant, cpu_grant, abort;
	logic        flash_sel, sram_sel, periph_sel, mem_wr, remap_active;
	logic [1:0]  dma_size, cpu_size, mem_size;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, dma_addr, dma_wdata, cpu_addr, cpu_wdata, mem_addr, mem_wdata;
	logic [31:0] st, aaddr, rd, a;
	int          miscompares, total_checks, seed, remap, nf, td, tc;
	memory_controller_unit #(.FLASH_AW(FAW), .SRAM_AW(SAW)) u_memory_controller_unit (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dma_req(dma_req), .dma_addr(dma_addr), .dma_wr(dma_wr), .dma_size(dma_size),
		.dma_wdata(dma_wdata), .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
		.cpu_fetch(cpu_fetch), .cpu_size(cpu_size), .cpu_wdata(cpu_wdata),
		.dma_grant(dma_grant), .cpu_grant(cpu_grant), .abort(abort), .flash_sel(flash_sel),
		.sram_sel(sram_sel), .periph_sel(periph_sel), .mem_wr(mem_wr), .mem_size(mem_size),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .remap_active(remap_active));
	bus_masters_model u_bus_masters_model (.pclk(pclk), .dma_grant(dma_grant),
		.cpu_grant(cpu_grant), .abort(abort), .dma_req(dma_req), .dma_addr(dma_addr),
		.dma_wr(dma_wr), .dma_size(dma_size), .dma_wdata(dma_wdata), .cpu_req(cpu_req),
		.cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_fetch(cpu_fetch), .cpu_size(cpu_size),
		.cpu_wdata(cpu_wdata));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp, input string m);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, ad, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
		#1;
	endtask
	task automatic go(input bit d, input logic [31:0] x, input logic w, f, input logic [1:0] s);
		logic u, m, fl, sr, pe;
		u = !(x[31:28] inside {4'h0, 4'hF}) || (x[31:28] == 4'h0 && x[27:20] > 8'h03);
		m = !f && ((s == 2'h2 && x[1:0] != 2'h0) || (s == 2'h1 && x[0]));
		fl = !u && !m && (x[31:20] == 12'h001 || (x[31:20] == 12'h000 && remap == 0));
		sr = !u && !m && (x[31:20] == 12'h002 || (x[31:20] == 12'h000 && remap == 1));
		pe = !u && !m && x[31:28] == 4'hF;
		u_bus_masters_model.access(d, x, w, f, s, x ^ 32'h5A5A_0F0F, g);
		chk(g, 1, "grant");
		chk(d ? cpu_grant : dma_grant, 0, "other grant");
		chk(abort, u | m, "abort");
		chk({flash_sel, sram_sel, periph_sel}, {fl, sr, pe}, "select");
		chk(mem_wr, w && (fl || sr || pe), "write strobe");
		chk(mem_size, s, "size");
		chk(mem_wdata, x ^ 32'h5A5A_0F0F, "write data");
		if (fl || sr)
			chk(mem_addr, x & ((32'h1 << (fl ? FAW : SAW)) - 1), "alias");
		if (pe)
			chk(mem_addr, x, "peripheral address");
		if (u || m) begin
			nf += !d;
			st[1:0] = {m, u};
			st[11:8] = {f ? 2'h2 : {1'b0, w}, s};
			st[17:16] = {!d, d};
			st[25:24] |= {!d, d};
			aaddr = x;
		end
	endtask
	task automatic status_check();
		apb(0, 8'h04, 32'h0, rd, er);
		chk(rd, st, "status");
		st[25:24] = 2'h0;
		apb(0, 8'h08, 32'h0, rd, er);
		chk(rd, aaddr, "abort address");
	endtask
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, st, aaddr} = '0;
		{miscompares, total_checks, remap, nf} = '0;
		seed = 32'h2793;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		chk(remap_active, 0, "remap reset");
		status_check();
		apb(1, 8'h00, 32'h0, rd, er);
		chk(remap_active, 0, "remap kept");
		for (int k = 0; k < 4; k++) begin
			apb(1, 8'h00, 32'h1, rd, er);
			remap ^= 1;
			chk(remap_active, remap, "remap toggle");
			go(0, 32'h0000_0100, 1'b0, 1'b0, 2'h2);
			go(1, 32'h0020_0104, 1'b1, 1'b0, 2'h2);
			go(0, 32'h0012_0108, 1'b0, 1'b0, 2'h1);
		end
		go(1, 32'h1000_0000, 1'b0, 1'b0, 2'h2);
		go(0, 32'h0030_0010, 1'b1, 1'b0, 2'h2);
		go(0, 32'h0010_0002, 1'b0, 1'b1, 2'h2);
		go(0, 32'h0021_0001, 1'b1, 1'b0, 2'h1);
		status_check();
		fork
			begin u_bus_masters_model.access(1, 32'h0020_0000, 0, 0, 2'h2, 0, g); td = $time; end
			begin u_bus_masters_model.access(0, 32'h0010_0000, 0, 0, 2'h2, 0, g); tc = $time; end
		join
		chk(tc > td, 1, "priority");
		for (int i = 0; i < 64; i++) begin
			a = $random(seed);
			if (a[5])
				a[31:23] = 9'h000;
			if (a[4])
				a[31:28] = 4'hF;
			go(a[9], a, a[8], !a[9] && !a[8] && a[10], a[7:6] % 2'h3);
			if (i % 8 == 7)
				status_check();
		end
		chk(u_bus_masters_model.cpu_faults, nf, "cpu aborts");
		apb(0, 8'h0C, 32'h0, rd, er);
		chk(er, 1, "unmapped");
		chk(rd, 0, "unmapped data");
		apb(1, 8'h04, 32'hFFFF_FFFF, rd, er);
		chk(er, 0, "status write error");
		status_check();
		apb(1, 8'h00, 32'h1, rd, er);
		chk(remap_active, 1, "remap before reset");
		go(1, 32'h2000_0000, 1'b1, 1'b0, 2'h0);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		{remap, st, aaddr} = '0;
		#1;
		chk(remap_active, 0, "remap after reset");
		status_check();
		go(0, 32'h0000_0040, 1'b0, 1'b0, 2'h2);
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		complete_run();
	end
endmodule
